// ==== pin_mux_pkg.sv ====
// constants shared by the pin multiplexer and its leaf modules
// assumes a byte-addressed bus slave with one 32-bit word per register
package pin_mux_pkg;

	// ==========================================
	// register map
	localparam int         ADDR_W       = 5;
	localparam logic [4:0] OFF_GPIO_EN  = 5'h00;
	localparam logic [4:0] OFF_GPIO_DIR = 5'h04;
	localparam logic [4:0] OFF_GPIO_OUT = 5'h08;
	localparam logic [4:0] OFF_GPIO_IN  = 5'h0C;
	localparam logic [4:0] OFF_STRAP    = 5'h10;

	// ==========================================
	// reset values
	localparam logic [15:0] GPIO_EN_RST  = 16'h0000;
	localparam logic [15:0] GPIO_DIR_RST = 16'h0000;
	localparam logic [15:0] GPIO_OUT_RST = 16'h0000;
	localparam logic        WAIT_RST     = 1'b1;

	// ==========================================
	// widths and pin positions
	localparam int HOST_W          = 32;
	localparam int NARROW_W        = 16;
	localparam int GPIO_W          = 16;
	localparam int GP_LOW_W        = 9;
	localparam int GP_PCI_LO       = 9;
	localparam int GP_PCI_W        = 7;
	localparam int GP_QUARTER      = 1;
	localparam int GP_SIXTH        = 2;
	localparam int GP_SERIAL_TWO   = 8;
	localparam int WIDTH_STRAP_BIT = 5;
	localparam int SC_W            = 7;
	localparam int SOLO_W          = 4;

	// ==========================================
	// strap vector and strap status fields
	localparam int STRAP_N     = 3;
	localparam int STRAP_WIDTH = 0;
	localparam int STRAP_CELL  = 1;
	localparam int STRAP_PCI   = 2;
	localparam int ST_VALID    = 0;
	localparam int ST_WIDE     = 1;
	localparam int ST_CELL     = 2;
	localparam int ST_PCI      = 3;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} bus_state_e;

endpackage

// ==== strap_capture.sv ====
// strap sampler: catches the strap levels once after reset release
// assumes strap inputs are steady around the release of reset_n
module strap_capture
	import pin_mux_pkg::*;
(
	input  wire logic               clock,
	input  wire logic               reset_n,
	input  wire logic [STRAP_N-1:0] raw,
	output logic      [STRAP_N-1:0] held,
	output logic                    valid
);

	// ==========================================
	// capture
	// the async reset may only load constants, so the real levels are
	// taken on the first clock edge after release
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			held  <= '0;
			valid <= 1'b0;
		end else if (!valid) begin
			held  <= raw;
			valid <= 1'b1;
		end
	end

	// ==========================================
	// checks
	a_strap_hold_stable: assert property (
		@(posedge clock) disable iff (!reset_n)
		valid |=> valid && $stable(held))
		else $error("strap values changed after capture");

endmodule

// ==== pad_select.sv ====
// two-way pad owner select with registered pad drive and core inputs
// assumes sel is steady while a pad group is in use
module pad_select
	import pin_mux_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         reset_n,
	input  wire logic         active,
	input  wire logic         sel,
	input  wire logic [W-1:0] pad_in,
	input  wire logic [W-1:0] a_dout,
	input  wire logic [W-1:0] a_doe,
	output logic      [W-1:0] a_din,
	input  wire logic [W-1:0] b_dout,
	input  wire logic [W-1:0] b_doe,
	output logic      [W-1:0] b_din,
	output logic      [W-1:0] pad_out,
	output logic      [W-1:0] pad_oe
);

	logic [W-1:0] next_out;
	logic [W-1:0] next_oe;

	// ==========================================
	// owner mux: the side not selected sees zero, never the pad
	assign next_out = sel ? b_dout : a_dout;
	assign next_oe  = active ? (sel ? b_doe : a_doe) : '0;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pad_out <= '0;
			pad_oe  <= '0;
			a_din   <= '0;
			b_din   <= '0;
		end else begin
			pad_out <= next_out;
			pad_oe  <= next_oe;
			a_din   <= (active && !sel) ? pad_in : '0;
			b_din   <= (active && sel) ? pad_in : '0;
		end
	end

endmodule

// ==== host_width_and_pin_mux.sv ====
// pin multiplexer: host width strap, strap owned groups, gpio handover
// assumes straps on the pads at reset release and an avalon master
//
// Functional notes
// - width strap low: 16-bit host, upper float unless pci owns them
// - width strap high: all 32 host bits used
// - software selected pins follow writes any time
// - strap owned groups have at most one owner
// - clock pins default on, gpio after enable
// - direction bit 0 input, 1 driven output
// - gpio 15..9 only without pci selected
// - serial one owns shared pins unless cell
// - unselected standalone pins float
// - host owns host/pci pins unless pci strap
module host_width_and_pin_mux
	import pin_mux_pkg::*;
(
	input  wire logic                    clock,
	input  wire logic                    reset_n,
	input  wire logic [ADDR_W-1:0]       address,
	input  wire logic                    read,
	input  wire logic                    write,
	input  wire logic [31:0]             writedata,
	input  wire logic [3:0]              byteenable,
	output logic      [31:0]             readdata,
	output logic                         waitrequest,
	input  wire logic                    cell_port_select_strap,
	input  wire logic                    pci_select_strap,
	output logic                         narrow_host_mode,
	output logic                         host_port_enable,
	output logic                         pci_enable,
	output logic                         cell_port_enable,
	input  wire logic [HOST_W-1:0]       host_data_bus_in,
	output logic      [HOST_W-1:0]       host_data_bus_out,
	output logic      [HOST_W-1:0]       host_data_bus_oe,
	input  wire logic [HOST_W-1:0]       host_port_dout,
	input  wire logic [HOST_W-1:0]       host_port_doe,
	output logic      [HOST_W-1:0]       host_port_din,
	input  wire logic [HOST_W-1:0]       pci_ad_dout,
	input  wire logic [HOST_W-1:0]       pci_ad_doe,
	output logic      [HOST_W-1:0]       pci_ad_din,
	input  wire logic                    quarter_rate_clock_src,
	input  wire logic                    sixth_rate_clock_src,
	output logic                         serial_two_external_clock,
	input  wire logic [GPIO_W-1:0]       gpio_pad_in,
	output logic      [GPIO_W-1:0]       gpio_pad_out,
	output logic      [GPIO_W-1:0]       gpio_pad_oe,
	input  wire logic [GP_PCI_W-1:0]     pci_gp_dout,
	input  wire logic [GP_PCI_W-1:0]     pci_gp_doe,
	output logic      [GP_PCI_W-1:0]     pci_gp_din,
	input  wire logic [SC_W-1:0]         ser_cell_pad_in,
	output logic      [SC_W-1:0]         ser_cell_pad_out,
	output logic      [SC_W-1:0]         ser_cell_pad_oe,
	input  wire logic [SC_W-1:0]         serial_one_dout,
	input  wire logic [SC_W-1:0]         serial_one_doe,
	output logic      [SC_W-1:0]         serial_one_din,
	input  wire logic [SC_W-1:0]         cell_dout,
	input  wire logic [SC_W-1:0]         cell_doe,
	output logic      [SC_W-1:0]         cell_din,
	input  wire logic [SOLO_W-1:0]       serial_solo_pad_in,
	output logic      [SOLO_W-1:0]       serial_solo_pad_out,
	output logic      [SOLO_W-1:0]       serial_solo_pad_oe,
	input  wire logic [SOLO_W-1:0]       serial_solo_dout,
	input  wire logic [SOLO_W-1:0]       serial_solo_doe,
	output logic      [SOLO_W-1:0]       serial_solo_din,
	input  wire logic [SOLO_W-1:0]       cell_solo_pad_in,
	output logic      [SOLO_W-1:0]       cell_solo_pad_out,
	output logic      [SOLO_W-1:0]       cell_solo_pad_oe,
	input  wire logic [SOLO_W-1:0]       cell_solo_dout,
	input  wire logic [SOLO_W-1:0]       cell_solo_doe,
	output logic      [SOLO_W-1:0]       cell_solo_din
);
	import pin_mux_pkg::*;

	// ==========================================
	// declarations
	bus_state_e           state;
	bus_state_e           next_state;
	logic                 next_wait;
	logic [31:0]          next_rdata;
	logic                 bus_req;
	logic                 wr_commit;
	logic [15:0]          gpio_enable;
	logic [15:0]          gpio_direction;
	logic [15:0]          gpio_out;
	logic [STRAP_N-1:0]   straps;
	logic [STRAP_N-1:0]   held;
	logic                 strap_valid;
	logic                 held_pci;
	logic                 held_cell;
	logic [HOST_W-1:0]    width_mask;
	logic [HOST_W-1:0]    host_doe_masked;
	logic [GP_LOW_W-1:0]  low_out;
	logic [GP_LOW_W-1:0]  low_oe;
	logic [GP_LOW_W-1:0]  low_out_q;
	logic [GP_LOW_W-1:0]  low_oe_q;
	logic [GP_PCI_W-1:0]  hi_out_q;
	logic [GP_PCI_W-1:0]  hi_oe_q;
	logic [GP_PCI_W-1:0]  gp_hi_drv;
	logic [31:0]          strap_word;

	function automatic logic [15:0] be_merge(
		input logic [15:0] old,
		input logic [31:0] wd,
		input logic [3:0]  be
	);
		be_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	// ==========================================
	// strap capture
	assign straps[STRAP_WIDTH] = host_data_bus_in[WIDTH_STRAP_BIT];
	assign straps[STRAP_CELL]  = cell_port_select_strap;
	assign straps[STRAP_PCI]   = pci_select_strap;
	assign held_pci            = held[STRAP_PCI];
	assign held_cell           = held[STRAP_CELL];

	strap_capture u_straps (
		.clock   (clock),
		.reset_n (reset_n),
		.raw     (straps),
		.held    (held),
		.valid   (strap_valid)
	);

	// ==========================================
	// ownership flags, one owner per strap group
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			narrow_host_mode <= 1'b1;
			host_port_enable <= 1'b0;
			pci_enable       <= 1'b0;
			cell_port_enable <= 1'b0;
		end else begin
			// narrow until capture, so upper pins never drive early
			narrow_host_mode <= !held[STRAP_WIDTH];
			host_port_enable <= strap_valid && !held_pci;
			pci_enable       <= strap_valid && held_pci;
			cell_port_enable <= strap_valid && held_cell;
		end
	end

	// ==========================================
	// host data bus, host port against pci
	// narrow mode masks the upper host port enables so those pins float; the pci enables pass unmasked
	assign width_mask = narrow_host_mode ? {{(HOST_W-NARROW_W){1'b0}},
		{NARROW_W{1'b1}}} : {HOST_W{1'b1}};
	assign host_doe_masked = host_port_doe & width_mask;

	pad_select #(.W(HOST_W)) u_host_pads (
		.clock   (clock),
		.reset_n (reset_n),
		.active  (strap_valid),
		.sel     (held_pci),
		.pad_in  (host_data_bus_in),
		.a_dout  (host_port_dout),
		.a_doe   (host_doe_masked),
		.a_din   (host_port_din),
		.b_dout  (pci_ad_dout),
		.b_doe   (pci_ad_doe),
		.b_din   (pci_ad_din),
		.pad_out (host_data_bus_out),
		.pad_oe  (host_data_bus_oe)
	);

	// ==========================================
	// shared serial one / cell address pins and standalone groups
	pad_select #(.W(SC_W)) u_ser_cell_pads (
		.clock   (clock),
		.reset_n (reset_n),
		.active  (strap_valid),
		.sel     (held_cell),
		.pad_in  (ser_cell_pad_in),
		.a_dout  (serial_one_dout),
		.a_doe   (serial_one_doe),
		.a_din   (serial_one_din),
		.b_dout  (cell_dout),
		.b_doe   (cell_doe),
		.b_din   (cell_din),
		.pad_out (ser_cell_pad_out),
		.pad_oe  (ser_cell_pad_oe)
	);

	pad_select #(.W(SOLO_W)) u_serial_solo (
		.clock   (clock),
		.reset_n (reset_n),
		.active  (strap_valid),
		.sel     (held_cell),
		.pad_in  (serial_solo_pad_in),
		.a_dout  (serial_solo_dout),
		.a_doe   (serial_solo_doe),
		.a_din   (serial_solo_din),
		.b_dout  ('0),
		.b_doe   ('0),
		.b_din   (),
		.pad_out (serial_solo_pad_out),
		.pad_oe  (serial_solo_pad_oe)
	);

	pad_select #(.W(SOLO_W)) u_cell_solo (
		.clock   (clock),
		.reset_n (reset_n),
		.active  (strap_valid),
		.sel     (held_cell),
		.pad_in  (cell_solo_pad_in),
		.a_dout  ('0),
		.a_doe   ('0),
		.a_din   (),
		.b_dout  (cell_solo_dout),
		.b_doe   (cell_solo_doe),
		.b_din   (cell_solo_din),
		.pad_out (cell_solo_pad_out),
		.pad_oe  (cell_solo_pad_oe)
	);

	// ==========================================
	// gpio pins 15..9, pci owned when the pci strap is set
	assign gp_hi_drv = gpio_enable[GPIO_W-1:GP_PCI_LO]
		& gpio_direction[GPIO_W-1:GP_PCI_LO];

	pad_select #(.W(GP_PCI_W)) u_gp_hi (
		.clock   (clock),
		.reset_n (reset_n),
		.active  (strap_valid),
		.sel     (held_pci),
		.pad_in  (gpio_pad_in[GPIO_W-1:GP_PCI_LO]),
		.a_dout  (gpio_out[GPIO_W-1:GP_PCI_LO]),
		.a_doe   (gp_hi_drv),
		.a_din   (),
		.b_dout  (pci_gp_dout),
		.b_doe   (pci_gp_doe),
		.b_din   (pci_gp_din),
		.pad_out (hi_out_q),
		.pad_oe  (hi_oe_q)
	);

	// ==========================================
	// gpio pins 8..0, clock functions by default on pins 1, 2 and 8
	// clocks are retimed by one flop, so they carry a cycle of delay
	for (genvar i = 0; i < GP_LOW_W; i++) begin : g_low
		if (i == GP_QUARTER || i == GP_SIXTH) begin : g_clk
			assign low_out[i] = gpio_enable[i] ? gpio_out[i] :
				(i == GP_QUARTER ? quarter_rate_clock_src
				: sixth_rate_clock_src);
			assign low_oe[i] = gpio_enable[i] ? gpio_direction[i] : 1'b1;
		end else begin : g_plain
			assign low_out[i] = gpio_out[i];
			assign low_oe[i] = gpio_enable[i] & gpio_direction[i];
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			low_out_q                 <= '0;
			low_oe_q                  <= '0;
			serial_two_external_clock <= 1'b0;
		end else begin
			low_out_q                 <= low_out;
			low_oe_q                  <= low_oe;
			serial_two_external_clock <= !gpio_enable[GP_SERIAL_TWO]
				&& gpio_pad_in[GP_SERIAL_TWO];
		end
	end

	assign gpio_pad_out = {hi_out_q, low_out_q};
	assign gpio_pad_oe  = {hi_oe_q, low_oe_q};

	// ==========================================
	// avalon slave: one wait cycle, then the answer
	assign bus_req   = read || write;
	assign wr_commit = (state == BUS_ACK) && write;
	assign next_wait = !((state == BUS_IDLE) && bus_req);
	assign strap_word = {28'h0000000, held_pci, held_cell,
		held[STRAP_WIDTH], strap_valid};

	always_comb begin
		next_state = state;
		unique case (state)
			BUS_IDLE: begin
				next_state = bus_req ? BUS_ACK : BUS_IDLE;
			end
			BUS_ACK: begin
				next_state = BUS_IDLE;
			end
			default: begin
				next_state = BUS_IDLE;
			end
		endcase
	end

	// unmapped offsets read zero and drop writes
	assign next_rdata =
		(address == OFF_GPIO_EN)  ? {16'h0000, gpio_enable} :
		(address == OFF_GPIO_DIR) ? {16'h0000, gpio_direction} :
		(address == OFF_GPIO_OUT) ? {16'h0000, gpio_out} :
		(address == OFF_GPIO_IN)  ? {16'h0000, gpio_pad_in} :
		(address == OFF_STRAP)    ? strap_word : 32'h00000000;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state       <= BUS_IDLE;
			waitrequest <= WAIT_RST;
			readdata    <= 32'h00000000;
		end else begin
			state       <= next_state;
			waitrequest <= next_wait;
			readdata    <= next_rdata;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			gpio_enable    <= GPIO_EN_RST;
			gpio_direction <= GPIO_DIR_RST;
			gpio_out       <= GPIO_OUT_RST;
		end else if (wr_commit) begin
			if (address == OFF_GPIO_EN)
				gpio_enable <= be_merge(gpio_enable, writedata, byteenable);
			if (address == OFF_GPIO_DIR)
				gpio_direction <= be_merge(gpio_direction, writedata,
					byteenable);
			if (address == OFF_GPIO_OUT)
				gpio_out <= be_merge(gpio_out, writedata, byteenable);
		end
	end

	// ==========================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	a_narrow_upper_float: assert property (
		strap_valid && narrow_host_mode |=> host_data_bus_oe[31:16] == 16'h0000)
		else $error("upper host pins driven in narrow mode");
	a_wide_all_bits: assert property (
		strap_valid && !narrow_host_mode && !held_pci
		|=> host_data_bus_oe == $past(host_port_doe))
		else $error("wide host enables not passed");
	a_gpio_write_takes: assert property (
		wr_commit && address == OFF_GPIO_EN && byteenable == 4'hF
		|=> gpio_enable == $past(writedata[15:0]))
		else $error("gpio enable write lost");
	a_pci_owns_group: assert property (
		strap_valid && held_pci |=> host_port_din == 32'h00000000
		&& host_port_enable == 1'b0)
		else $error("host port still sees pci pins");
	a_clock_pin_default: assert property (
		reset_n && !gpio_enable[GP_QUARTER] |=> gpio_pad_oe[GP_QUARTER]
		&& gpio_pad_out[GP_QUARTER] == $past(quarter_rate_clock_src))
		else $error("quarter clock not on its pin");
	a_gpio_direction: assert property (
		gpio_enable[0] |=> gpio_pad_oe[0] == $past(gpio_direction[0]))
		else $error("gpio direction not honoured");
	a_gp_high_pci: assert property (
		strap_valid && held_pci |=> gpio_pad_oe[15:9] == $past(pci_gp_doe))
		else $error("pci lost gpio 15..9");
	a_serial_default: assert property (
		strap_valid && !held_cell |=> ser_cell_pad_oe == $past(serial_one_doe))
		else $error("serial one not on shared pins");
	a_solo_float: assert property (
		strap_valid && held_cell |=> serial_solo_pad_oe == 4'h0
		##0 cell_solo_pad_oe == $past(cell_solo_doe))
		else $error("standalone pins not floated");
	a_host_default: assert property (
		strap_valid && !held_pci
		|=> host_data_bus_out[15:0] == $past(host_port_dout[15:0]))
		else $error("host port does not own its pins");
	a_bus_answer: assert property (
		bus_req && waitrequest && state == BUS_IDLE |=> !waitrequest)
		else $error("bus answer late");

	c_narrow_mode: cover property (strap_valid && narrow_host_mode);
	c_cell_select: cover property (strap_valid && held_cell);
	c_pci_select: cover property (strap_valid && held_pci);
	c_gpio_write: cover property (wr_commit && address == OFF_GPIO_EN);

endmodule

// ==== board_host_model.sv ====
// board side: strap resistors and an outside host on the host data pads
// assumes the bench sets the strap levels while reset is low
module board_host_model
	import pin_mux_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              reset_n,
	input  wire logic              strap_wide,
	input  wire logic              strap_cell,
	input  wire logic              strap_pci,
	input  wire logic              host_drive,
	input  wire logic [HOST_W-1:0] host_val,
	input  wire logic [HOST_W-1:0] pad_out,
	input  wire logic [HOST_W-1:0] pad_oe,
	output logic      [HOST_W-1:0] pad_in,
	output logic                   cell_strap,
	output logic                   pci_strap
);
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================
	// pad levels
	logic [HOST_W-1:0] float_pat = 32'h55AA55AA;
	logic              host_on;

	// released lines toggle so no stale level passes for a drive
	always @(posedge clock) begin
		float_pat <= ~float_pat;
	end

	// outside host keeps off the bus while reset is low
	assign host_on = reset_n & host_drive;
	assign cell_strap = strap_cell;
	assign pci_strap = strap_pci;

	always_comb begin
		for (int i = 0; i < HOST_W; i++) begin
			if (pad_oe[i])
				pad_in[i] = pad_out[i];
			else if (host_on)
				pad_in[i] = host_val[i];
			else if (i == WIDTH_STRAP_BIT)
				pad_in[i] = strap_wide;
			else
				pad_in[i] = float_pat[i];
		end
	end
endmodule

// ==== host_width_and_pin_mux_tb.sv ====
// self-checking bench for the pin multiplexer
// assumes the board model on the host pads and an avalon master here
module host_width_and_pin_mux_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import pin_mux_pkg::*;

	// ==========================================
	// signals
	logic                clock, reset_n, read, write, waitrequest;
	logic [ADDR_W-1:0]   address;
	logic [31:0]         writedata, readdata, q;
	logic [3:0]          byteenable;
	logic                cell_port_select_strap, pci_select_strap;
	logic                narrow_host_mode, host_port_enable, pci_enable;
	logic                cell_port_enable, serial_two_external_clock;
	logic                quarter_rate_clock_src, sixth_rate_clock_src;
	logic                strap_wide, strap_cell, strap_pci, host_drive;
	logic [HOST_W-1:0]   host_data_bus_in, host_data_bus_out;
	logic [HOST_W-1:0]   host_data_bus_oe, host_val;
	logic [HOST_W-1:0]   host_port_dout, host_port_doe, host_port_din;
	logic [HOST_W-1:0]   pci_ad_dout, pci_ad_doe, pci_ad_din;
	logic [GPIO_W-1:0]   gpio_pad_in, gpio_pad_out, gpio_pad_oe;
	logic [GP_PCI_W-1:0] pci_gp_dout, pci_gp_doe, pci_gp_din;
	logic [SC_W-1:0]     ser_cell_pad_in, ser_cell_pad_out, ser_cell_pad_oe;
	logic [SC_W-1:0]     serial_one_dout, serial_one_doe, serial_one_din;
	logic [SC_W-1:0]     cell_dout, cell_doe, cell_din;
	logic [SOLO_W-1:0]   serial_solo_pad_in, serial_solo_pad_out;
	logic [SOLO_W-1:0]   serial_solo_pad_oe, serial_solo_dout;
	logic [SOLO_W-1:0]   serial_solo_doe, serial_solo_din;
	logic [SOLO_W-1:0]   cell_solo_pad_in, cell_solo_pad_out;
	logic [SOLO_W-1:0]   cell_solo_pad_oe, cell_solo_dout;
	logic [SOLO_W-1:0]   cell_solo_doe, cell_solo_din;
	int                  n_mismatch = 0;
	int                  checks_done = 0;

	host_width_and_pin_mux host_width_and_pin_mux_inst (.*);

	board_host_model board_host_model_inst (
		.clock(clock), .reset_n(reset_n), .strap_wide(strap_wide),
		.strap_cell(strap_cell), .strap_pci(strap_pci),
		.host_drive(host_drive), .host_val(host_val),
		.pad_out(host_data_bus_out), .pad_oe(host_data_bus_oe),
		.pad_in(host_data_bus_in), .cell_strap(cell_port_select_strap),
		.pci_strap(pci_select_strap)
	);

	always #12.5 clock = ~clock;

	// ==========================================
	// shared tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// request held until waitrequest is sampled low, then released
	task automatic bus_xfer(input logic wr, input logic [4:0] a,
		input logic [31:0] d, input logic [3:0] be);
		address <= a;
		writedata <= d;
		byteenable <= be;
		write <= wr;
		read <= !wr;
		@(posedge clock);
		while (waitrequest !== 1'b0) @(posedge clock);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus_xfer(1'b1, a, d, 4'hF);
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
		bus_xfer(1'b0, a, 32'h0, 4'hF);
		check(q, exp);
	endtask

	task automatic settle();
		repeat (3) @(posedge clock);
	endtask

	// straps are moved here only while reset is low
	task automatic do_reset(input logic w, input logic c, input logic p);
		reset_n <= 1'b0;
		strap_wide <= w;
		strap_cell <= c;
		strap_pci <= p;
		repeat (12) @(posedge clock);
		check(waitrequest, 1'b1);
		check(gpio_pad_oe, 16'h0000);
		reset_n <= 1'b1;
		repeat (3) @(posedge clock);
	endtask

	// ==========================================
	// scenarios
	task automatic t_narrow();
		do_reset(1'b0, 1'b0, 1'b0);
		host_port_dout <= 32'hA5A55A5A;
		host_port_doe <= 32'hFFFFFFFF;
		settle();
		check(narrow_host_mode, 1'b1);
		check(host_data_bus_oe, 32'h0000FFFF);
		check(host_data_bus_out[15:0], 16'h5A5A);
		check({host_port_enable, pci_enable, cell_port_enable}, 3'h4);
		check(gpio_pad_oe, 16'h0006);
		rd_chk(OFF_GPIO_EN, 32'h0);
		rd_chk(OFF_GPIO_DIR, 32'h0);
		rd_chk(OFF_STRAP, 32'h1);
		host_port_doe <= 32'h0;
	endtask

	task automatic t_wide();
		do_reset(1'b1, 1'b0, 1'b0);
		host_port_doe <= 32'hFFFFFFFF;
		settle();
		check(narrow_host_mode, 1'b0);
		check(host_data_bus_oe, 32'hFFFFFFFF);
		check(host_data_bus_out, 32'hA5A55A5A);
		host_port_doe <= 32'h0;
		host_drive <= 1'b1;
		settle();
		check(host_port_din, 32'h3C96E187);
		check(pci_ad_din, 32'h0);
		rd_chk(OFF_STRAP, 32'h3);
		host_drive <= 1'b0;
	endtask

	task automatic t_pci_gpio();
		do_reset(1'b1, 1'b0, 1'b1);
		pci_gp_doe <= 7'h33;
		pci_gp_dout <= 7'h5A;
		pci_ad_doe <= 32'h0000FF00;
		pci_ad_dout <= 32'h12345678;
		wr(OFF_GPIO_EN, 32'hFE00);
		wr(OFF_GPIO_DIR, 32'hAA00);
		settle();
		check({host_port_enable, pci_enable, cell_port_enable}, 3'h2);
		check(host_port_din, 32'h0);
		check(host_data_bus_oe, 32'h0000FF00);
		check(host_data_bus_out & 32'h0000FF00, 32'h00005600);
		check(pci_ad_din & 32'h0000FF00, 32'h00005600);
		check(gpio_pad_oe[15:9], 7'h33);
		check(gpio_pad_out[15:9] & 7'h33, 7'h12);
		check(pci_gp_din, 7'h61);
		rd_chk(OFF_STRAP, 32'hB);
		do_reset(1'b0, 1'b0, 1'b0);
		wr(OFF_GPIO_EN, 32'hFE00);
		wr(OFF_GPIO_DIR, 32'hAA00);
		settle();
		check(gpio_pad_oe[15:9], 7'h55);
		check(pci_gp_din, 7'h00);
	endtask

	task automatic t_clock_pins();
		do_reset(1'b0, 1'b0, 1'b0);
		quarter_rate_clock_src <= 1'b1;
		sixth_rate_clock_src <= 1'b0;
		settle();
		check(gpio_pad_out[2:1], 2'b01);
		quarter_rate_clock_src <= 1'b0;
		sixth_rate_clock_src <= 1'b1;
		settle();
		check(gpio_pad_out[2:1], 2'b10);
		check(serial_two_external_clock, 1'b1);
		wr(OFF_GPIO_EN, 32'h0106);
		wr(OFF_GPIO_DIR, 32'h0002);
		wr(OFF_GPIO_OUT, 32'h0006);
		settle();
		check(gpio_pad_oe, 16'h0002);
		check(gpio_pad_out[2:1], 2'b11);
		check(serial_two_external_clock, 1'b0);
		wr(OFF_GPIO_DIR, 32'h0104);
		settle();
		check(gpio_pad_oe, 16'h0104);
		bus_xfer(1'b1, OFF_GPIO_DIR, 32'h0000FFFF, 4'h2);
		rd_chk(OFF_GPIO_DIR, 32'hFF04);
		rd_chk(OFF_GPIO_IN, 32'hC3A5);
		wr(5'h14, 32'hFFFF);
		rd_chk(5'h14, 32'h0);
		rd_chk(OFF_GPIO_EN, 32'h0106);
	endtask

	task automatic t_cell();
		do_reset(1'b0, 1'b0, 1'b0);
		serial_one_doe <= 7'h5B;
		serial_one_dout <= 7'h55;
		cell_doe <= 7'h36;
		cell_dout <= 7'h2A;
		serial_solo_doe <= 4'hF;
		cell_solo_doe <= 4'hF;
		serial_solo_dout <= 4'hA;
		cell_solo_dout <= 4'h5;
		serial_solo_pad_in <= 4'h9;
		cell_solo_pad_in <= 4'h6;
		ser_cell_pad_in <= 7'h4C;
		settle();
		check(ser_cell_pad_oe, 7'h5B);
		check(ser_cell_pad_out & 7'h5B, 7'h51);
		check(serial_one_din, 7'h4C);
		check(cell_din, 7'h00);
		check({serial_solo_pad_oe, cell_solo_pad_oe}, 8'hF0);
		check({serial_solo_din, cell_solo_din}, 8'h90);
		check({serial_solo_pad_out, cell_solo_pad_out}, 8'hA0);
		// straps moved after capture must change nothing
		strap_cell <= 1'b1;
		strap_wide <= 1'b1;
		settle();
		check(cell_port_enable, 1'b0);
		check(narrow_host_mode, 1'b1);
		rd_chk(OFF_STRAP, 32'h1);
		do_reset(1'b0, 1'b1, 1'b0);
		settle();
		check(ser_cell_pad_oe, 7'h36);
		check(ser_cell_pad_out & 7'h36, 7'h22);
		check(cell_din, 7'h4C);
		check(serial_one_din, 7'h00);
		check({serial_solo_pad_oe, cell_solo_pad_oe}, 8'h0F);
		check({serial_solo_din, cell_solo_din}, 8'h06);
		check({serial_solo_pad_out, cell_solo_pad_out}, 8'h05);
		check({host_port_enable, pci_enable, cell_port_enable}, 3'h5);
		rd_chk(OFF_STRAP, 32'h5);
	endtask

	// ==========================================
	// run control
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		reset_n = 1'b0;
		{read, write, address, writedata, byteenable} = '0;
		{strap_wide, strap_cell, strap_pci, host_drive} = '0;
		host_val = 32'h3C96E187;
		{quarter_rate_clock_src, sixth_rate_clock_src} = '0;
		{host_port_dout, host_port_doe, pci_ad_dout, pci_ad_doe} = '0;
		gpio_pad_in = 16'hC3A5;
		{pci_gp_dout, pci_gp_doe, ser_cell_pad_in} = '0;
		{serial_one_dout, serial_one_doe, cell_dout, cell_doe} = '0;
		{serial_solo_pad_in, serial_solo_dout, serial_solo_doe} = '0;
		{cell_solo_pad_in, cell_solo_dout, cell_solo_doe} = '0;
		t_narrow();
		t_wide();
		t_pci_gpio();
		t_clock_pins();
		t_cell();
		conclude();
	end

	// whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clock);
		n_mismatch++;
		conclude();
	end
endmodule
